// ==== verilog/level_trigger_acquisition_timer.sv ====
// level trigger acquisition sequencer with single and continuous strobes
`timescale 1ns/1ps
`include "level_trigger_acquisition_timer_defines.svh"

module level_trigger_acquisition_timer
#(
    parameter int unsigned V0_MIN_PULSE_US = `LTA_V0_MIN_PULSE_US,
    parameter int unsigned V0_BUSY1_US     = `LTA_V0_BUSY1_US,
    parameter int unsigned V0_BUSY2_US     = `LTA_V0_BUSY2_US,
    parameter int unsigned V1_MIN_PULSE_US = `LTA_V1_MIN_PULSE_US,
    parameter int unsigned V1_BUSY1_US     = `LTA_V1_BUSY1_US,
    parameter int unsigned V1_BUSY2_US     = `LTA_V1_BUSY2_US
)
(
    input  wire logic                                     clk_sys,
    input  wire logic                                     arst_n,
    input  wire logic                                     trigger_in,
    input  wire level_trigger_acquisition_timer_pkg::acq_config_type cfg,
    output level_trigger_acquisition_timer_pkg::acq_status_type      status,
    output logic                                          trigger_event,
    output logic                                          acq_done,
    output logic                                          single_strobe,
    output logic                                          continuous_strobe
);
    import level_trigger_acquisition_timer_pkg::*;

    localparam int TW = `LTA_TIME_W;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // asynchronous assert, synchronous release
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // trigger edge and timebase
    // ----------------------------------------------------------------
    logic          trig_prev;
    logic          tick_us;
    acq_state_type state;
    acq_state_type next_state;

    // new edges count only in idle, so final busy blocks them
    // triggers ignored while busy
    wire trig_rise = trigger_in && !trig_prev && (state == ST_IDLE);
    wire trig_fall = !trigger_in && trig_prev;
    // realign the us tick at the event and again when the window closes, so the
    // final busy time is whole; built from state, not next_state, to avoid a loop
    wire tick_restart = trigger_event
                     || (trig_fall && ((state == ST_BUSY_PRE) || (state == ST_ACQ_DELAY) || (state == ST_INTEGRATE)));

    // event one clock after the edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_prev     <= 1'b0;
            trigger_event <= 1'b0;
        end
        else
        begin
            trig_prev     <= trigger_in;
            trigger_event <= trig_rise;
        end
    end

    us_timebase u_timebase
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .restart (tick_restart),
        .tick_us (tick_us)
    );

    // ----------------------------------------------------------------
    // variant selection
    // ----------------------------------------------------------------
    wire [TW-1:0] min_pulse_us = cfg.variant_sel ? TW'(V1_MIN_PULSE_US) : TW'(V0_MIN_PULSE_US);
    wire [TW-1:0] busy1_us     = cfg.variant_sel ? TW'(V1_BUSY1_US) : TW'(V0_BUSY1_US);
    wire [TW-1:0] busy2_us     = cfg.variant_sel ? TW'(V1_BUSY2_US) : TW'(V0_BUSY2_US);

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    logic [TW-1:0] phase_us;     // microseconds spent in current state
    logic [TW-1:0] pulse_us;     // trigger high time since the event
    logic [TW-1:0] integ_us;     // microseconds into integration
    logic [TW-1:0] cs_count;
    logic          cs_level;
    logic          busy_flag;
    logic          integ_flag;
    logic          error_flag;
    logic          zero_flag;

    // status word gathered from its flag registers, one driver each
    assign status = '{busy: busy_flag, integrating: integ_flag, acq_error: error_flag, data_zero: zero_flag};

    wire           state_change = (next_state != state);
    wire [TW-1:0]  phase_inc    = phase_us + TW'(1);
    wire           busy1_done   = tick_us && (phase_inc == busy1_us);
    wire           delay_done   = tick_us && (phase_inc == TW'(cfg.acquisition_delay_time));
    wire           busy2_done   = tick_us && (phase_inc == busy2_us);
    wire           no_delay     = (cfg.acquisition_delay_time == '0);
    wire           in_window    = (state == ST_BUSY_PRE) || (state == ST_ACQ_DELAY) || (state == ST_INTEGRATE);
    // a pulse below the minimum is an error
    wire           short_pulse  = (pulse_us < min_pulse_us);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // trigger fall wins over every timer in the window
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (trigger_event)
                    next_state = ST_BUSY_PRE;
            ST_BUSY_PRE:
                if (trig_fall)
                    next_state = ST_BUSY_POST;
                else if (busy1_done)
                    next_state = no_delay ? ST_INTEGRATE : ST_ACQ_DELAY;
            ST_ACQ_DELAY:
                if (trig_fall)
                    next_state = ST_BUSY_POST;
                else if (delay_done)
                    next_state = ST_INTEGRATE;
            // integrate while the trigger stays high
            ST_INTEGRATE:
                if (trig_fall)
                    next_state = ST_BUSY_POST;
            ST_BUSY_POST:
                if (busy2_done)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // state register and phase counter
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ST_IDLE;
            phase_us <= '0;
        end
        else
        begin
            state <= next_state;
            if (state_change)
                phase_us <= '0;
            else if (tick_us)
                phase_us <= phase_inc;
        end
    end

    // pulse width measured from the event, saturating
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pulse_us <= '0;
        else if (trigger_event)
            pulse_us <= '0;
        else if (in_window && tick_us && pulse_us != '1)
            pulse_us <= pulse_us + TW'(1);
    end

    // error and zeroed data held until the next event
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            error_flag <= 1'b0;
            zero_flag  <= 1'b0;
        end
        else if (trigger_event)
        begin
            error_flag <= 1'b0;
            zero_flag  <= 1'b0;
        end
        else if (in_window && trig_fall && short_pulse)
        begin
            error_flag <= 1'b1;
            zero_flag  <= 1'b1;
        end
    end

    // status levels and end-of-cycle pulse
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_flag  <= 1'b0;
            integ_flag <= 1'b0;
            acq_done   <= 1'b0;
        end
        else
        begin
            busy_flag  <= (next_state != ST_IDLE);
            integ_flag <= (next_state == ST_INTEGRATE);
            acq_done   <= (state == ST_BUSY_POST) && busy2_done;
        end
    end

    // ----------------------------------------------------------------
    // strobes
    // ----------------------------------------------------------------
    wire          integ_next  = (next_state == ST_INTEGRATE);
    wire          integ_start = integ_next && (state != ST_INTEGRATE);
    wire [TW:0]   ss_end      = {1'b0, cfg.single_strobe_delay} + {1'b0, cfg.single_strobe_width};
    // zero width never fires; the window closes with integration
    wire          ss_window   = (integ_us >= cfg.single_strobe_delay) && ({1'b0, integ_us} < ss_end);
    wire          cs_enable   = (cfg.continuous_strobe_period != '0);
    wire          cs_wrap     = (cs_count == cfg.continuous_strobe_period - TW'(1));

    // integration clock in microseconds
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            integ_us <= '0;
        else if (integ_start)
            integ_us <= '0;
        else if (state == ST_INTEGRATE && tick_us && integ_us != '1)
            integ_us <= integ_us + TW'(1);
    end

    // continuous strobe toggles every programmed interval
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_count <= '0;
            cs_level <= 1'b0;
        end
        else if (!integ_next || integ_start)
        begin
            cs_count <= '0;
            cs_level <= integ_start && cs_enable;
        end
        else if (tick_us && cs_enable)
        begin
            cs_count <= cs_wrap ? '0 : cs_count + TW'(1);
            if (cs_wrap)
                cs_level <= !cs_level;
        end
    end

    // strobe outputs gated by the next state so they drop with integration
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            single_strobe     <= 1'b0;
            continuous_strobe <= 1'b0;
        end
        else
        begin
            single_strobe     <= integ_next && !integ_start && ss_window;
            continuous_strobe <= integ_next && cs_level;
        end
    end

endmodule : level_trigger_acquisition_timer

// ==== include/level_trigger_acquisition_timer_defines.svh ====
// timing constants and widths for the level trigger acquisition timer
`ifndef LEVEL_TRIGGER_ACQUISITION_TIMER_DEFINES_SVH
`define LEVEL_TRIGGER_ACQUISITION_TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------
`define LTA_CLK_PERIOD_NS     100
`define LTA_US_IN_NS          1000
`define LTA_CYC_PER_US        (`LTA_US_IN_NS / `LTA_CLK_PERIOD_NS)
`define LTA_RECOG_MIN_NS      20
`define LTA_RECOG_MAX_NS      30
// least time rounds up, never below one cycle
`define LTA_RECOG_CYC         ((`LTA_RECOG_MIN_NS + `LTA_CLK_PERIOD_NS - 1) / `LTA_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define LTA_TIME_W            24
`define LTA_DELAY_W           19
`define LTA_TB_W              4

// ----------------------------------------------------------------
// variant timing in microseconds (variant 0 / variant 1)
// ----------------------------------------------------------------
`define LTA_V0_MIN_PULSE_US   3800
`define LTA_V0_MAX_PULSE_US   10000000
`define LTA_V0_BUSY1_US       3706
`define LTA_V0_BUSY2_US       3706
`define LTA_V1_MIN_PULSE_US   7200
`define LTA_V1_MAX_PULSE_US   5000000
`define LTA_V1_BUSY1_US       6
`define LTA_V1_BUSY2_US       4977
`define LTA_ACQ_DELAY_MAX_US  335500

`endif

// ==== include/level_trigger_acquisition_timer_pkg.sv ====
// types shared by the level trigger acquisition timer
package level_trigger_acquisition_timer_pkg;

    // acquisition sequence
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_BUSY_PRE,
        ST_ACQ_DELAY,
        ST_INTEGRATE,
        ST_BUSY_POST
    } acq_state_type;

    // user settings, all but variant_sel in microseconds
    typedef struct packed
    {
        logic        variant_sel;
        logic [18:0] acquisition_delay_time;
        logic [23:0] single_strobe_delay;
        logic [23:0] single_strobe_width;
        logic [23:0] continuous_strobe_period;
    } acq_config_type;

    // observable state
    typedef struct packed
    {
        logic busy;
        logic integrating;
        logic acq_error;
        logic data_zero;
    } acq_status_type;

endpackage : level_trigger_acquisition_timer_pkg

// ==== verilog/us_timebase.sv ====
// restartable 1 us tick generator
`timescale 1ns/1ps
`include "level_trigger_acquisition_timer_defines.svh"

module us_timebase
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      tick_us
);

    localparam logic [`LTA_TB_W-1:0] LAST = `LTA_TB_W'(`LTA_CYC_PER_US - 1);

    logic [`LTA_TB_W-1:0] count;
    logic [`LTA_TB_W-1:0] next_count;
    wire                  at_last = (count == LAST);

    // restart aligns the first tick exactly one us after the event
    assign next_count = (restart || at_last) ? '0 : count + `LTA_TB_W'(1);
    assign tick_us    = at_last && !restart;

    // divider register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else
            count <= next_count;
    end

endmodule : us_timebase

// ==== testbench/lta_checker.sv ====
// assertion checker bound to the acquisition timer ports
`timescale 1ns/1ps

module lta_checker
#(
    parameter int unsigned V0_BUSY1_US = 5,
    parameter int unsigned V1_BUSY1_US = 1
)
(
    input wire logic                                          clk_sys,
    input wire logic                                          arst_n,
    input wire logic                                          trigger_in,
    input wire level_trigger_acquisition_timer_pkg::acq_config_type cfg,
    input wire level_trigger_acquisition_timer_pkg::acq_status_type status,
    input wire logic                                          trigger_event,
    input wire logic                                          acq_done,
    input wire logic                                          single_strobe,
    input wire logic                                          continuous_strobe
);
    import level_trigger_acquisition_timer_pkg::*;

    logic [31:0] ev_cnt;
    logic [31:0] cs_cnt;
    logic        cs_last;
    logic        cs_armed;
    logic [31:0] pre_cyc;
    logic [31:0] cs_cyc;
    logic        cs_edge;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // settings are read live, as the sequencer does
    assign pre_cyc = 32'(10 * ((cfg.variant_sel ? V1_BUSY1_US : V0_BUSY1_US) + cfg.acquisition_delay_time));
    assign cs_cyc  = 32'(10 * cfg.continuous_strobe_period);
    assign cs_edge = continuous_strobe != cs_last;

    // cycles since the event and since the last strobe toggle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ev_cnt   <= 32'h0;
            cs_cnt   <= 32'h0;
            cs_last  <= 1'b0;
            cs_armed <= 1'b0;
        end
        else
        begin
            ev_cnt   <= trigger_event ? 32'h1 : ev_cnt + 32'h1;
            cs_cnt   <= cs_edge ? 32'h0 : cs_cnt + 32'h1;
            cs_last  <= continuous_strobe;
            cs_armed <= status.integrating && (cs_armed || cs_edge);
        end
    end

    // ----------------------------------------------------------------
    // output relations
    // ----------------------------------------------------------------
    a_event_from_edge: assert property (trigger_event |-> $past(trigger_in) && !$past(trigger_in, 2))
        else $error("trigger event without a rising edge");
    a_event_one_cycle: assert property (trigger_event |=> !trigger_event)
        else $error("trigger event longer than one cycle");
    a_busy_after_event: assert property (trigger_event |=> status.busy)
        else $error("busy missing after trigger event");
    a_integ_start_time: assert property ($rose(status.integrating) |-> ev_cnt >= pre_cyc && ev_cnt <= pre_cyc + 32'h3)
        else $error("integration start off the busy plus delay time");
    a_integ_holds_level: assert property (status.integrating && trigger_in |=> status.integrating)
        else $error("integration ended while trigger high");
    a_integ_ends_fall: assert property (status.integrating && !trigger_in |=> !status.integrating)
        else $error("integration outlived the trigger level");
    a_strobes_low_end: assert property ($fell(status.integrating) |-> !single_strobe && !continuous_strobe)
        else $error("strobe still high after integration");
    a_strobes_idle_low: assert property (!status.busy |-> !single_strobe && !continuous_strobe)
        else $error("strobe high while idle");
    a_cs_period_exact: assert property (cs_edge && status.integrating && cs_armed |-> cs_cnt + 32'h1 == cs_cyc)
        else $error("continuous strobe toggle spacing wrong");
    a_post_busy_hold: assert property ($fell(status.integrating) |-> status.busy [*8])
        else $error("busy dropped right after integration");
    a_no_retrigger: assert property (status.busy && $past(status.busy) |-> !trigger_event)
        else $error("trigger accepted while busy");
    a_done_to_idle: assert property (acq_done |=> !acq_done && !status.busy)
        else $error("busy still set after completion");
    a_error_mirror: assert property (status.acq_error == status.data_zero)
        else $error("data zero flag differs from error flag");
    a_error_clear: assert property ($fell(status.acq_error) |-> trigger_event || $past(trigger_event))
        else $error("error flag cleared without a new event");
endmodule : lta_checker

bind level_trigger_acquisition_timer lta_checker
#(
    .V0_BUSY1_US(V0_BUSY1_US),
    .V1_BUSY1_US(V1_BUSY1_US)
)
u_lta_checker
(
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .trigger_in(trigger_in),
    .cfg(cfg),
    .status(status),
    .trigger_event(trigger_event),
    .acq_done(acq_done),
    .single_strobe(single_strobe),
    .continuous_strobe(continuous_strobe)
);

// ==== testbench/trigger_source.sv ====
// external trigger source model driving the level trigger pin
`timescale 1ns/1ps

module trigger_source
(
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [31:0] len,
    output logic             trig
);
    logic [31:0] rem = 32'h0;

    initial trig = 1'b0;

    // pin moves on the falling edge; a new pulse starts only from low
    // holds the level for the commanded width
    always @(negedge clk_sys)
    begin
        if (go && rem == 32'h0)
            rem <= len;
        else if (rem != 32'h0)
            rem <= rem - 32'h1;
        trig <= (go && rem == 32'h0) ? (len != 32'h0) : (rem > 32'h1);
    end
endmodule : trigger_source

// ==== testbench/tb_top.sv ====
// self-checking bench for the level trigger acquisition timer
`timescale 1ns/1ps
`include "level_trigger_acquisition_timer_defines.svh"

module tb_top;
    import level_trigger_acquisition_timer_pkg::*;

    typedef struct packed
    {
        logic        err;
        logic [31:0] integ;
        logic [31:0] ss;
        logic        cs_on;
    } res_type;

    logic           clk_sys     = 1'b0;
    logic           arst_n      = 1'b0;
    logic           go          = 1'b0;
    logic [31:0]    len         = 32'h0;
    logic           trig;
    acq_config_type cfg         = '0;
    acq_status_type status;
    logic           trigger_event;
    logic           acq_done;
    logic           single_strobe;
    logic           continuous_strobe;
    res_type        exp_q [$];
    res_type        got         = '0;
    res_type        e;
    int             checks      = 0;
    int             miscompares = 0;
    logic [7:0]     r           = 8'h37;
    // variant, delay, high us, strobe delay, width, period, refused pulse
    int             tbl [6][7]  = '{'{0, 0, 18, 1, 2, 1, 0}, '{0, 0, 3, 0, 1, 1, 0}, '{0, 0, 40, 2, 3, 3, 0},
                                    '{1, 4, 60, 2, 0, 0, 0}, '{1, 0, 28, 3, 2, 2, 0}, '{1, 2, 40, 100, 2, 2, 1}};

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    // short busy and width limits keep the run brief; variant 1 keeps its real initial busy
    level_trigger_acquisition_timer
    #(
        .V0_MIN_PULSE_US(20), .V0_BUSY1_US(5), .V0_BUSY2_US(5),
        .V1_MIN_PULSE_US(30), .V1_BUSY2_US(8)
    )
    DUT
    (
        .clk_sys(clk_sys), .arst_n(arst_n), .trigger_in(trig), .cfg(cfg), .status(status),
        .trigger_event(trigger_event), .acq_done(acq_done), .single_strobe(single_strobe),
        .continuous_strobe(continuous_strobe)
    );

    trigger_source u_src (.clk_sys(clk_sys), .go(go), .len(len), .trig(trig));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic cmp_val(input logic [31:0] ex, input logic [31:0] gt);
        checks++;
        if (gt !== ex)
        begin
            miscompares++;
            $display("[ERR] %0t exp=%h got=%h", $time, ex, gt);
        end
    endtask : cmp_val

    // integration length may shift by a cycle or two at each end
    task automatic cmp_near(input logic [31:0] ex, input logic [31:0] gt);
        logic ok;
        ok = (gt + 32'h3 >= ex) && (gt <= ex + 32'h3);
        checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t exp=%h got=%h", $time, ex, gt);
        end
    endtask : cmp_near

    task automatic pulse(input int n);
        @(negedge clk_sys);
        go  <= 1'b1;
        len <= 32'(n);
        @(negedge clk_sys);
        go  <= 1'b0;
        repeat (n + 2) @(negedge clk_sys);
    endtask : pulse

    // one acquisition: note the expectation, then drive the pulse
    task automatic run(input int s [7], input int rnd);
        res_type x;
        int      sw;
        int      it;
        int      i;
        sw      = (s[4] != 0) ? s[4] + rnd : 0;
        it      = s[2] - (s[0] != 0 ? `LTA_V1_BUSY1_US : 5) - s[1];
        it      = (it < 0) ? 0 : it;
        x.err   = s[2] < (s[0] != 0 ? 30 : 20);
        x.integ = 32'(10 * it);
        x.ss    = (s[3] + sw <= it) ? 32'(10 * sw) : 32'h0;
        x.cs_on = (s[5] != 0) && (it > 0);
        exp_q.push_back(x);
        @(negedge clk_sys);
        cfg <= {1'(s[0]), 19'(s[1]), 24'(s[3]), 24'(sw), 24'(s[5])};
        pulse(10 * s[2]);
        if (s[6] != 0)
            pulse(20);
        for (i = 0; i < 2000 && acq_done !== 1'b1; i++)
            @(negedge clk_sys);
        if (i == 2000)
        begin
            miscompares++;
            wrap_up();
        end
    endtask : run

    // monitor: gather one acquisition and judge it at completion
    always @(posedge clk_sys)
    begin
        if (trigger_event === 1'b1)
            got = '0;
        got.integ = got.integ + 32'(status.integrating);
        got.ss    = got.ss + 32'(single_strobe);
        got.cs_on = got.cs_on | continuous_strobe;
        if (acq_done === 1'b1)
        begin
            cmp_val(32'h1, 32'(exp_q.size() != 0));
            if (exp_q.size() != 0)
            begin
                e = exp_q.pop_front();
                cmp_val(32'(e.err), 32'(status.acq_error));
                cmp_val(32'(e.err), 32'(status.data_zero));
                cmp_near(e.integ, got.integ);
                cmp_val(e.ss, got.ss);
                cmp_val(32'(e.cs_on), 32'(got.cs_on));
            end
        end
    end

    // main sequence: reset, the scenario table, then the verdict
    initial
    begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 6; i++)
        begin
            r = lfsr(r);
            run(tbl[i], int'(r[1:0]));
            $display("test %0d done", i);
        end
        repeat (20) @(negedge clk_sys);
        cmp_val(32'h0, 32'(exp_q.size()));
        wrap_up();
    end
endmodule : tb_top
